// >>> rtl/sys_ctrl.sv
// System control: banking, RAM guard, six-source interrupt unit, two timers,
// port drive configuration, power-on one-shot and sleep modes.
// Assumes pins and core strobes are synchronous to mclk.
`timescale 1ns/1ps
module sys_ctrl
	import sys_ctrl_pkg::*;
#(
	parameter int PorCycles = POR_CYCLES,
	parameter bit RamProtFitted = 1'b1
)(
	input wire logic mclk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic [7:0] regAddr, // Register address
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	input wire logic [7:0] regWrData, // Write data
	output logic [7:0] regRdData, // Read data, one cycle after strobe
	input wire logic [7:0] ramAddr, // General register access address
	output logic ramBlocked, // Access to protected area refused
	input wire logic extStack, // Stack lives in external memory
	output logic [15:0] stackPtr, // Effective stack pointer
	output logic [3:0] workGroup, // Working register group
	output logic [3:0] regBank, // Selected register bank
	input wire logic port3LineOne, // Line one pin
	input wire logic port3LineTwo, // Line two pin
	input wire logic port3LineThree, // Line three pin
	input wire logic dspIrqN, // DSP request, falling edge
	output logic intPending, // Enabled request waiting
	input wire logic intAck, // Core starts service
	output logic [15:0] intVecAddr, // Vector byte pair address
	output portCfg_t portCfg, // Port drive settings
	input wire logic powerOk, // Supply valid
	input wire logic wdtTimeout, // Watchdog expiry pulse
	input wire logic wakeEvent, // Wake source seen in deep sleep
	input wire logic haltCmd, // Light-sleep instruction
	input wire logic stopCmd, // Deep-sleep instruction
	output logic coreResetN, // Core held in reset, active low
	output logic cpuClkRun, // Core clock enabled
	output logic xtalRun, // Crystal enabled
	output logic [15:0] restartAddr // Start address after reset
);
	// ------------------------------------------------------------
	// Registers and helpers
	// ------------------------------------------------------------
	logic [7:0] imr_r, irq_r, prio_r, wp_r, sph_r, spl_r, tmode_r, port_drive_config_r, p45_r, wake_r, dspc_r;
	logic [7:0] cnt_r [2];
	logic [7:0] init_r [2];
	logic [7:0] pre_r [2];
	logic [5:0] preCnt_r [2];
	logic [1:0] act_r, tcEnd, srcTick;
	logic [1:0] div4_r;
	logic p31_r, p32_r, p33_r, dsp_r, pwrOk_r;
	logic [2:0] grantSrc_r;
	logic [15:0] vec_r;
	logic [16:0] porCnt_r;
	logic [5:0] irqSet;
	pwr_t pwr_r;
	logic bankF, irqWr, imrWr, dspcWr, tmWr, intTick, t1Trig, porTrig;
	t1mode_t t1Mode;

	function automatic logic edgeHit(input logic prev, input logic cur, input logic rise, input logic fall);
		return (rise & !prev & cur) | (fall & prev & !cur);
	endfunction

	function automatic logic [2:0] pickSrc(input logic [5:0] pend, input logic [2:0] first);
		logic [2:0] pick;
		logic found;
		int idx;
		pick = 3'd0;
		found = 1'b0;
		for (int k = 0; k < NUM_SRC; k++)
		begin
			idx = (int'(first) + k) % NUM_SRC;
			if (!found && pend[idx])
			begin
				pick = 3'(idx);
				found = 1'b1;
			end
		end
		return pick;
	endfunction

	// ------------------------------------------------------------
	// Decode and combinational outputs
	// ------------------------------------------------------------
	// Bank F holds the low sixteen addresses only while the window selects it
	assign bankF = (wp_r[3:0] == BANK_F) && (regAddr[7:4] == 4'h0);
	assign irqWr = regWr && (regAddr == ADDR_IRQ);
	assign imrWr = regWr && (regAddr == ADDR_IMR);
	assign dspcWr = regWr && bankF && (regAddr[3:0] == EXT_DSPC);
	assign tmWr = regWr && (regAddr == ADDR_TMODE);
	assign workGroup = wp_r[7:4];
	assign regBank = wp_r[3:0];
	assign stackPtr = extStack ? {sph_r, spl_r} : {8'h00, spl_r};
	assign ramBlocked = RamProtFitted && imr_r[IMR_RAMPROT]
		&& (ramAddr >= RAM_PROT_LO) && (ramAddr <= RAM_PROT_HI);
	assign intPending = imr_r[IMR_GLOBAL] && |(irq_r[5:0] & imr_r[5:0]);
	assign intVecAddr = vec_r;
	assign portCfg = '{port_drive_config_r[PORT_DRIVE_CONFIG_CMP], port_drive_config_r[PORT_DRIVE_CONFIG_P0], port_drive_config_r[PORT_DRIVE_CONFIG_P1], p45_r[P45_P4], p45_r[P45_P5]};
	assign coreResetN = (pwr_r != PWR_POR);
	assign cpuClkRun = (pwr_r == PWR_RUN);
	assign xtalRun = (pwr_r != PWR_STOP);
	assign restartAddr = STOP_RESTART_ADDR;
	assign t1Mode = t1mode_t'(tmode_r[TM_MODE_LO +: 2]);
	assign intTick = (div4_r == 2'd3) && (pwr_r != PWR_STOP);
	assign t1Trig = (t1Mode == T1_TRIG_NR || t1Mode == T1_TRIG_RT) && tmode_r[TM_RUN1] && p31_r && !port3LineOne
		&& (t1Mode == T1_TRIG_RT || !act_r[1]);

	// Timer clock sources: timer zero internal only, timer one selectable
	always_comb
	begin
		srcTick[0] = intTick;
		if (tmode_r[TM_CASCADE])
			srcTick[1] = tcEnd[0];
		else if (pre_r[1][PRE_INTCLK])
			srcTick[1] = intTick;
		else if (t1Mode == T1_GATE)
			srcTick[1] = intTick && port3LineOne;
		else if (t1Mode == T1_EXTCLK)
			srcTick[1] = p31_r && !port3LineOne;
		else
			srcTick[1] = intTick;
	end

	// Expiry is a single cycle: prescaler wraps and counter sits at one
	always_comb
	begin
		for (int i = 0; i < 2; i++)
			tcEnd[i] = act_r[i] && srcTick[i] && (preCnt_r[i] == 6'd0) && (cnt_r[i] == 8'd1);
	end

	// Request sources
	always_comb
	begin
		irqSet[0] = edgeHit(p32_r, port3LineTwo, irq_r[IRQ_EDGE_LO], !irq_r[IRQ_EDGE_LO] | irq_r[IRQ_EDGE_HI]);
		irqSet[1] = edgeHit(p33_r, port3LineThree, 1'b0, 1'b1);
		irqSet[2] = edgeHit(p31_r, port3LineOne, irq_r[IRQ_EDGE_HI], !irq_r[IRQ_EDGE_HI] | irq_r[IRQ_EDGE_LO]);
		irqSet[3] = edgeHit(dsp_r, dspIrqN, 1'b0, 1'b1);
		irqSet[4] = tcEnd[0];
		irqSet[5] = tcEnd[1];
	end

	// ------------------------------------------------------------
	// Edge history and internal divide by four
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			{p31_r, p32_r, p33_r, dsp_r, pwrOk_r} <= 5'b11110;
			div4_r <= 2'd0;
		end
		else
		begin
			{p31_r, p32_r, p33_r, dsp_r, pwrOk_r} <= {port3LineOne, port3LineTwo, port3LineThree, dspIrqN, powerOk};
			div4_r <= div4_r + 2'd1;
		end
	end

	// ------------------------------------------------------------
	// Interrupt unit: latch, mask, priority, grant
	// ------------------------------------------------------------
	// Latch sets regardless of mask so software may poll; set beats any clear
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			irq_r <= RST_ZERO;
		else
		begin
			for (int s = 0; s < NUM_SRC; s++)
			begin
				if (irqSet[s])
					irq_r[s] <= 1'b1;
				else if (irqWr)
					irq_r[s] <= regWrData[s];
				else if (intAck && grantSrc_r == 3'(s))
					irq_r[s] <= 1'b0;
				else if (s == 3 && dspcWr && regWrData[DSPC_REQUEST_THREE])
					irq_r[s] <= 1'b0;
			end
			if (irqWr)
				irq_r[7:6] <= regWrData[7:6];
		end
	end

	// Winner and vector refreshed every cycle so they are stable when acked
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			grantSrc_r <= 3'd0;
			vec_r <= 16'h0000;
		end
		else
		begin
			grantSrc_r <= pickSrc(irq_r[5:0] & imr_r[5:0], prio_r[2:0]);
			vec_r <= {12'h000, pickSrc(irq_r[5:0] & imr_r[5:0], prio_r[2:0]), 1'b0};
		end
	end

	// Mask register; a grant drops the global enable
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			imr_r <= RST_ZERO;
		else if (intAck)
			imr_r[IMR_GLOBAL] <= 1'b0;
		else if (imrWr)
			imr_r <= regWrData;
	end

	// ------------------------------------------------------------
	// Plain control registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			{prio_r, wp_r, sph_r, spl_r, tmode_r, dspc_r} <= {6{RST_ZERO}};
			port_drive_config_r <= RST_PORT_DRIVE_CONFIG;
			p45_r <= RST_P45;
		end
		else if (regWr)
		begin
			if (regAddr == ADDR_PRIO)
				prio_r <= regWrData;
			if (regAddr == ADDR_WP)
				wp_r <= regWrData;
			if (regAddr == ADDR_SPH)
				sph_r <= regWrData;
			if (regAddr == ADDR_SPL)
				spl_r <= regWrData;
			if (tmWr)
				tmode_r <= regWrData & 8'h7A;
			if (bankF && regAddr[3:0] == EXT_PORT_DRIVE_CONFIG)
				port_drive_config_r <= regWrData;
			if (bankF && regAddr[3:0] == EXT_P45)
				p45_r <= regWrData;
			if (dspcWr)
				dspc_r <= regWrData & 8'hF2;
		end
	end

	// ------------------------------------------------------------
	// Counter/timers
	// ------------------------------------------------------------
	// A zero divider field means divide by 64, a zero count means 256
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 2; i++)
			begin
				cnt_r[i] <= RST_ZERO;
				init_r[i] <= RST_ZERO;
				pre_r[i] <= RST_ZERO;
				preCnt_r[i] <= 6'd0;
			end
			act_r <= 2'b00;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (srcTick[i] && act_r[i])
				begin
					preCnt_r[i] <= (preCnt_r[i] == 6'd0) ? pre_r[i][7:2] - 6'd1 : preCnt_r[i] - 6'd1;
					if (preCnt_r[i] == 6'd0)
					begin
						if (cnt_r[i] == 8'd1)
						begin
							cnt_r[i] <= pre_r[i][PRE_CONT] ? init_r[i] : 8'd0;
							act_r[i] <= pre_r[i][PRE_CONT];
						end
						else
							cnt_r[i] <= cnt_r[i] - 8'd1;
					end
				end
				// Trigger modes do not arm on the run bit unless PRE_INTCLK is set, but clearing it still stops a count
				if (tmWr && (i == 0 || t1Mode == T1_EXTCLK || t1Mode == T1_GATE || pre_r[1][PRE_INTCLK]
					|| !regWrData[TM_RUN1]))
					act_r[i] <= regWrData[(i == 0) ? TM_RUN0 : TM_RUN1];
				if ((tmWr && regWrData[(i == 0) ? TM_LOAD0 : TM_LOAD1]) || (i == 1 && t1Trig))
				begin
					cnt_r[i] <= init_r[i];
					preCnt_r[i] <= pre_r[i][7:2] - 6'd1;
					if (i == 1 && t1Trig)
						act_r[i] <= 1'b1;
				end
				if (regWr && regAddr == ((i == 0) ? ADDR_T0 : ADDR_T1))
					init_r[i] <= regWrData;
				if (regWr && regAddr == ((i == 0) ? ADDR_PRE0 : ADDR_PRE1))
					pre_r[i] <= regWrData;
			end
		end
	end

	// ------------------------------------------------------------
	// Power modes and power-on one-shot
	// ------------------------------------------------------------
	assign porTrig = (powerOk && !pwrOk_r) || wdtTimeout || (pwr_r == PWR_STOP && wakeEvent && wake_r[WAKE_PORDLY]);

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pwr_r <= PWR_POR;
			porCnt_r <= 17'd0;
			wake_r <= RST_WAKE;
		end
		else
		begin
			if (regWr && bankF && regAddr[3:0] == EXT_WAKE)
				wake_r[6:0] <= regWrData[6:0];
			if (!powerOk || porTrig)
			begin
				pwr_r <= PWR_POR;
				porCnt_r <= 17'd0;
				if (!powerOk)
					wake_r[WAKE_WARM] <= 1'b0;
			end
			else
			begin
				case (pwr_r)
					PWR_POR:
					begin
						porCnt_r <= porCnt_r + 17'd1;
						if (porCnt_r >= 17'(PorCycles - 1))
							pwr_r <= PWR_RUN;
					end
					PWR_RUN:
					begin
						if (stopCmd)
						begin
							pwr_r <= PWR_STOP;
							wake_r[WAKE_WARM] <= 1'b1;
						end
						else if (haltCmd)
							pwr_r <= PWR_HALT;
					end
					PWR_HALT:
					begin
						if (|irqSet)
							pwr_r <= PWR_RUN;
					end
					PWR_STOP:
					begin
						if (wakeEvent)
							pwr_r <= PWR_RUN;
					end
					default:
						pwr_r <= PWR_POR;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Read data, registered; counters read live without side effects
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			regRdData <= RST_ZERO;
		else if (regRd)
		begin
			if (bankF)
			begin
				case (regAddr[3:0])
					EXT_PORT_DRIVE_CONFIG: regRdData <= port_drive_config_r;
					EXT_P45: regRdData <= p45_r;
					EXT_WAKE: regRdData <= {wake_r[WAKE_WARM], 7'd0};
					EXT_DSPC: regRdData <= {dspc_r[7:1], irq_r[3]};
					default: regRdData <= RST_ZERO;
				endcase
			end
			else
			begin
				case (regAddr)
					ADDR_TMODE: regRdData <= tmode_r;
					ADDR_T1: regRdData <= cnt_r[1];
					ADDR_T0: regRdData <= cnt_r[0];
					ADDR_PRIO: regRdData <= prio_r;
					ADDR_IRQ: regRdData <= irq_r;
					ADDR_IMR: regRdData <= imr_r;
					ADDR_WP: regRdData <= wp_r;
					ADDR_SPH: regRdData <= sph_r;
					ADDR_SPL: regRdData <= spl_r;
					default: regRdData <= RST_ZERO;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_ack;
		intAck;
	endsequence
	sequence s_globalOff;
		!imr_r[IMR_GLOBAL] ##0 !intPending;
	endsequence
	property p_ramProt;
		@(posedge mclk) disable iff (!rstn) (imr_r[IMR_RAMPROT] && ramAddr == RAM_PROT_HI) |-> ramBlocked;
	endproperty
	a_ramProt: assert property (p_ramProt) else $error("protected address not blocked");
	property p_grant;
		@(posedge mclk) disable iff (!rstn) s_ack |=> s_globalOff;
	endproperty
	a_grant: assert property (p_grant) else $error("grant left interrupts enabled");
	property p_vec;
		@(posedge mclk) disable iff (!rstn) (!vec_r[0] && vec_r <= 16'd10);
	endproperty
	a_vec: assert property (p_vec) else $error("vector address out of table");
	property p_dspReq;
		@(posedge mclk) disable iff (!rstn) (dsp_r && !dspIrqN) |=> irq_r[3];
	endproperty
	a_dspReq: assert property (p_dspReq) else $error("DSP request lost");
	property p_line3;
		@(posedge mclk) disable iff (!rstn) (p33_r && !port3LineThree) |=> irq_r[1];
	endproperty
	a_line3: assert property (p_line3) else $error("line three request lost");
	property p_maskedLatch;
		@(posedge mclk) disable iff (!rstn) tcEnd[0] |=> irq_r[4];
	endproperty
	a_maskedLatch: assert property (p_maskedLatch) else $error("timer request not latched");
	property p_onePulse;
		@(posedge mclk) disable iff (!rstn) tcEnd[1] |=> !tcEnd[1] [*3];
	endproperty
	a_onePulse: assert property (p_onePulse) else $error("expiry pulse repeated");
	property p_stopHold;
		@(posedge mclk) disable iff (!rstn) (pwr_r == PWR_STOP && !wakeEvent && !porTrig && powerOk) |=> !xtalRun;
	endproperty
	a_stopHold: assert property (p_stopHold) else $error("deep sleep left without reset");
endmodule

// >>> rtl/sys_ctrl_pkg.sv
// Constants, types and register map for the system-control block.
// Assumes a single 20 MHz system clock and an 8-bit register port from the core.
package sys_ctrl_pkg;
	// ------------------------------------------------------------
	// Register offsets in the standard control page
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_TMODE = 8'hF1;
	localparam logic [7:0] ADDR_T1 = 8'hF2;
	localparam logic [7:0] ADDR_PRE1 = 8'hF3;
	localparam logic [7:0] ADDR_T0 = 8'hF4;
	localparam logic [7:0] ADDR_PRE0 = 8'hF5;
	localparam logic [7:0] ADDR_PRIO = 8'hF9;
	localparam logic [7:0] ADDR_IRQ = 8'hFA;
	localparam logic [7:0] ADDR_IMR = 8'hFB;
	localparam logic [7:0] ADDR_WP = 8'hFD;
	localparam logic [7:0] ADDR_SPH = 8'hFE;
	localparam logic [7:0] ADDR_SPL = 8'hFF;
	// ------------------------------------------------------------
	// Banked register space, bank F
	// ------------------------------------------------------------
	localparam logic [3:0] BANK_F = 4'hF;
	localparam logic [3:0] EXT_PORT_DRIVE_CONFIG = 4'h0;
	localparam logic [3:0] EXT_P45 = 4'h6;
	localparam logic [3:0] EXT_WAKE = 4'hB;
	localparam logic [3:0] EXT_DSPC = 4'hC;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int IMR_GLOBAL = 7;
	localparam int IMR_RAMPROT = 6;
	localparam int IRQ_EDGE_HI = 7;
	localparam int IRQ_EDGE_LO = 6;
	localparam int PORT_DRIVE_CONFIG_CMP = 0;
	localparam int PORT_DRIVE_CONFIG_P0 = 1;
	localparam int PORT_DRIVE_CONFIG_P1 = 2;
	localparam int P45_P4 = 0;
	localparam int P45_P5 = 4;
	localparam int WAKE_PORDLY = 5;
	localparam int WAKE_WARM = 7;
	localparam int DSPC_REQUEST_THREE = 0;
	localparam int TM_LOAD0 = 0;
	localparam int TM_RUN0 = 1;
	localparam int TM_LOAD1 = 2;
	localparam int TM_RUN1 = 3;
	localparam int TM_MODE_LO = 4;
	localparam int TM_CASCADE = 6;
	localparam int PRE_CONT = 0;
	localparam int PRE_INTCLK = 1;
	localparam int PRE_DIV_LO = 2;
	// ------------------------------------------------------------
	// Reset values, limits and timing
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PORT_DRIVE_CONFIG = 8'h06;
	localparam logic [7:0] RST_P45 = 8'h11;
	localparam logic [7:0] RST_WAKE = 8'h20;
	localparam logic [7:0] RAM_PROT_LO = 8'h80;
	localparam logic [7:0] RAM_PROT_HI = 8'hEF;
	localparam logic [15:0] STOP_RESTART_ADDR = 16'h000C;
	localparam int NUM_SRC = 6;
	localparam int CLK_MHZ = 20;
	localparam int POR_TIME_US = 5000;
	localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PWR_RUN = 2'b00, PWR_HALT = 2'b01, PWR_STOP = 2'b10, PWR_POR = 2'b11} pwr_t;
	typedef enum logic [1:0] {T1_EXTCLK = 2'b00, T1_GATE = 2'b01, T1_TRIG_NR = 2'b10, T1_TRIG_RT = 2'b11} t1mode_t;
	typedef struct packed {
		logic cmpToPort3;
		logic port0PushPull;
		logic port1PushPull;
		logic port4PushPull;
		logic port5PushPull;
	} portCfg_t;
endpackage

// >>> testbench/core_partner.sv
// Behavioural model of the core and the DSP beside the block.
// Assumes the block samples intAck and dspIrqN on rising mclk.
`timescale 1ns/1ps
module core_partner (
	input wire logic mclk, // System clock
	input wire logic intPending, // Enabled request waiting
	input wire logic ackEn, // Core accepts interrupts
	input wire logic dspReq, // Bench asks the DSP to signal
	output logic intAck, // Service start pulse
	output logic dspIrqN // DSP request line, idle high
);
	logic [1:0] waitCnt;
	initial
	begin
		waitCnt = 2'd0;
		intAck = 1'b0;
		dspIrqN = 1'b1;
	end
	// Ack only once the vector has had a cycle to settle
	always @(posedge mclk)
	begin
		waitCnt <= (ackEn && intPending && !intAck) ? waitCnt + 2'd1 : 2'd0;
		intAck <= ackEn && intPending && !intAck && waitCnt == 2'd1;
	end
	// DSP pulls its line low while asked, then releases high
	always @(posedge mclk)
		dspIrqN <= !dspReq;
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the system-control block.
// Assumes the core partner model and a shortened one-shot.
`timescale 1ns/1ps
module testbench import sys_ctrl_pkg::*; ;
	logic mclk, rstn, regWr, regRd, extStack, ramBlocked, intPending, intAck;
	logic lineOne, lineTwo, lineThree, dspIrqN, dspReq, ackEn, powerOk;
	logic wdtTimeout, wakeEvent, haltCmd, stopCmd, coreResetN, cpuClkRun, xtalRun;
	logic [7:0] regAddr, regWrData, regRdData, ramAddr, v;
	logic [15:0] stackPtr, intVecAddr, restartAddr;
	logic [3:0] workGroup, regBank;
	portCfg_t portCfg;
	int fail_count = 0;
	int n_checks = 0;
	int i;
	sys_ctrl #(.PorCycles(20)) sys_ctrl_i (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
		.regRd(regRd), .regWrData(regWrData), .regRdData(regRdData), .ramAddr(ramAddr),
		.ramBlocked(ramBlocked), .extStack(extStack), .stackPtr(stackPtr), .workGroup(workGroup),
		.regBank(regBank), .port3LineOne(lineOne), .port3LineTwo(lineTwo), .port3LineThree(lineThree),
		.dspIrqN(dspIrqN), .intPending(intPending), .intAck(intAck), .intVecAddr(intVecAddr),
		.portCfg(portCfg), .powerOk(powerOk), .wdtTimeout(wdtTimeout), .wakeEvent(wakeEvent),
		.haltCmd(haltCmd), .stopCmd(stopCmd), .coreResetN(coreResetN), .cpuClkRun(cpuClkRun),
		.xtalRun(xtalRun), .restartAddr(restartAddr));
	core_partner core_partner_i (.mclk(mclk), .intPending(intPending), .ackEn(ackEn), .dspReq(dspReq),
		.intAck(intAck), .dspIrqN(dspIrqN));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = !mclk;
	end
	task automatic report_and_stop();
		if (fail_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	// Read data is registered, so it is taken a cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		v = regRdData;
	endtask
	// Bounded wait; a hang shows up as a failed compare, not a stall
	task automatic waitFor(ref logic sig, input logic lvl);
		for (int k = 0; k < 60 && sig !== lvl; k++)
			@(negedge mclk);
	endtask
	// One-cycle pulse on {wdtTimeout, wakeEvent, haltCmd, stopCmd}
	task automatic pulse(input logic [3:0] sel);
		@(posedge mclk);
		{wdtTimeout, wakeEvent, haltCmd, stopCmd} <= sel;
		@(posedge mclk);
		{wdtTimeout, wakeEvent, haltCmd, stopCmd} <= 4'h0;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rstn, regWr, regRd, extStack, dspReq, ackEn, wdtTimeout, wakeEvent, haltCmd, stopCmd} = '0;
		{lineOne, lineTwo, lineThree, powerOk} = 4'hF;
		{regAddr, regWrData, ramAddr} = '0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		chk("portCfg", portCfg, 5'b01111);
		chk("coreResetN", coreResetN, 1'b0);
		@(posedge mclk);
		rstn <= 1'b1;
		for (i = 0; i < 60 && coreResetN !== 1'b1; i++)
			@(negedge mclk);
		chk("porLong", i >= 18, 1'b1);
		chk("coreResetN", coreResetN, 1'b1);
		wr(ADDR_WP, 8'hAF);
		@(negedge mclk);
		chk("group", workGroup, 4'hA);
		chk("bank", regBank, 4'hF);
		rd({4'h0, EXT_PORT_DRIVE_CONFIG});
		chk("port_drive_config", v, 8'h06);
		rd({4'h0, EXT_P45});
		chk("p45", v, 8'h11);
		wr({4'h0, EXT_PORT_DRIVE_CONFIG}, 8'h01);
		wr({4'h0, EXT_P45}, 8'h10);
		@(negedge mclk);
		chk("portCfg", portCfg, 5'b10001);
		wr(ADDR_SPH, 8'h12);
		wr(ADDR_SPL, 8'h34);
		extStack <= 1'b1;
		@(negedge mclk);
		chk("spExt", stackPtr, 16'h1234);
		@(posedge mclk);
		extStack <= 1'b0;
		@(negedge mclk);
		chk("spInt", stackPtr, 16'h0034);
		// Guard edges on both sides of the protected span
		wr(ADDR_IMR, 8'h40);
		for (i = 0; i < 4; i++)
		begin
			@(posedge mclk);
			ramAddr <= (i == 0) ? 8'h80 : (i == 1) ? 8'hEF : (i == 2) ? 8'hF0 : 8'h7F;
			@(negedge mclk);
			chk("ramBlocked", ramBlocked, i < 2);
		end
		wr(ADDR_IMR, 8'h00);
		@(negedge mclk);
		chk("ramOpen", ramBlocked, 1'b0);
		// ------------------------------------------------------------
		// Interrupts
		// ------------------------------------------------------------
		wr(ADDR_IRQ, 8'h00);
		wr(ADDR_IMR, 8'h82);
		ackEn <= 1'b1;
		lineThree <= 1'b0;
		waitFor(intPending, 1'b1);
		@(negedge mclk);
		chk("vector", intVecAddr, 16'h0002);
		waitFor(intPending, 1'b0);
		chk("pendDone", intPending, 1'b0);
		rd(ADDR_IMR);
		chk("global", v[7], 1'b0);
		@(posedge mclk);
		lineThree <= 1'b1;
		ackEn <= 1'b0;
		@(posedge mclk);
		dspReq <= 1'b1;
		repeat (2) @(posedge mclk);
		dspReq <= 1'b0;
		rd(ADDR_IRQ);
		chk("dspLatch", v[3], 1'b1);
		chk("masked", intPending, 1'b0);
		wr({4'h0, EXT_DSPC}, 8'h01);
		rd(ADDR_IRQ);
		chk("dspClear", v[3], 1'b0);
		// Two latched sources; the priority start point picks the winner
		wr(ADDR_IRQ, 8'h28);
		wr(ADDR_IMR, 8'h28);
		wr(ADDR_PRIO, 8'h04);
		repeat (2) @(negedge mclk);
		chk("prioHi", intVecAddr, 16'h000A);
		wr(ADDR_PRIO, 8'h00);
		repeat (2) @(negedge mclk);
		chk("prioLo", intVecAddr, 16'h0006);
		// Line one falling, line two rising
		wr(ADDR_IRQ, 8'h40);
		lineTwo <= 1'b0;
		rd(ADDR_IRQ);
		chk("twoFall", v[5:0], 6'h00);
		@(posedge mclk);
		lineTwo <= 1'b1;
		@(posedge mclk);
		lineOne <= 1'b0;
		rd(ADDR_IRQ);
		chk("edges", v[5:0], 6'h05);
		@(posedge mclk);
		lineOne <= 1'b1;
		// ------------------------------------------------------------
		// Timer and sleep modes
		// ------------------------------------------------------------
		wr(ADDR_IRQ, 8'h00);
		wr(ADDR_PRE0, 8'h05);
		wr(ADDR_T0, 8'h02);
		wr(ADDR_TMODE, 8'h03);
		repeat (12) @(posedge mclk);
		rd(ADDR_IRQ);
		chk("t0Expire", v[5:0], 6'h10);
		wr(ADDR_TMODE, 8'h00);
		wr(ADDR_IRQ, 8'h00);
		// Timer one clocked by falling line-one edges, single pass from three
		wr(ADDR_PRE1, 8'h04);
		wr(ADDR_T1, 8'h03);
		wr(ADDR_TMODE, 8'h0C);
		rd(ADDR_T1);
		chk("t1Load", v, 8'h03);
		for (i = 0; i < 3; i++)
		begin
			@(posedge mclk);
			lineOne <= 1'b0;
			@(posedge mclk);
			lineOne <= 1'b1;
			rd(ADDR_T1);
			chk("t1Count", v, 8'(2 - i));
		end
		rd(ADDR_IRQ);
		chk("t1Expire", v[5:0], 6'h24);
		// Core has run its no-op flush before each sleep pulse
		pulse(4'h2);
		@(negedge mclk);
		chk("haltClk", {cpuClkRun, xtalRun}, 2'b01);
		@(posedge mclk);
		lineThree <= 1'b0;
		waitFor(cpuClkRun, 1'b1);
		chk("haltWake", cpuClkRun, 1'b1);
		@(posedge mclk);
		lineThree <= 1'b1;
		pulse(4'h1);
		repeat (4) @(negedge mclk);
		chk("stopClk", {cpuClkRun, xtalRun}, 2'b00);
		pulse(4'h4);
		waitFor(coreResetN, 1'b0);
		chk("wakePor", coreResetN, 1'b0);
		waitFor(coreResetN, 1'b1);
		chk("wakeRun", {coreResetN, xtalRun}, 2'b11);
		chk("restart", restartAddr, STOP_RESTART_ADDR);
		pulse(4'h8);
		@(negedge mclk);
		chk("wdtPor", coreResetN, 1'b0);
		waitFor(coreResetN, 1'b1);
		report_and_stop();
	end
	// Whole run needs well under 2000 cycles
	initial
	begin
		#200000;
		fail_count++;
		report_and_stop();
	end
endmodule
